// ===== design/comparator_offset_trim_irq.sv
`timescale 1ns/1ns
// Comparator control: enable, polarity, offset trim, toggle interrupt and wake-up.
module comparator_offset_trim_irq (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Register port.
	input wire logic [comparator_pkg::ADDR_W-1:0] regAddr,
	input wire logic [comparator_pkg::DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [comparator_pkg::DATA_W-1:0] regRdata,
	// Analog comparator.
	input wire logic compareRaw,
	output logic comparatorOn,
	output logic hysteresisOn,
	output logic calibrationModeSel,
	output logic calibReferenceSel,
	output logic [comparator_pkg::TRIM_W-1:0] offsetTrimValue,
	// System.
	input wire logic sleepMode,
	output logic irq,
	output logic wakeRequest,
	output logic compareResultBit
);
	comparator_pkg::bus_req_t req;
	comparator_pkg::analog_ctl_t ctl;
	logic [7:0] control_r;
	logic [7:0] trim_r;
	logic [1:0] status_r;
	logic [1:0] mask_r;
	logic [1:0] statusNxt;
	logic result;
	logic resultPrev_r;
	logic toggle;
	logic wakeEvt;
	logic [7:0] readNxt;

	// Group the bus signals as one carrier.
	always_comb begin
		req.addr = regAddr;
		req.wdata = regWdata;
		req.wr = regWr;
		req.rd = regRd;
	end

	// Software-owned control bits; the result bit position is read-only.
	always_ff @(posedge clk) begin
		if (reset) begin
			control_r <= 8'h00;
		end else if (req.wr && req.addr == comparator_pkg::ADDR_CONTROL) begin
			control_r <= 8'h00;
			control_r[comparator_pkg::CTL_ON_BIT] <= req.wdata[comparator_pkg::CTL_ON_BIT];
			control_r[comparator_pkg::CTL_INV_BIT] <= req.wdata[comparator_pkg::CTL_INV_BIT];
		end
	end

	// Trim register keeps its value until software writes it again.
	always_ff @(posedge clk) begin
		if (reset) begin
			trim_r <= comparator_pkg::TRIM_RESET;
		end else if (req.wr && req.addr == comparator_pkg::ADDR_TRIM) begin
			trim_r <= req.wdata & comparator_pkg::TRIM_WMASK;
		end
	end

	result_sync u_sync (
		.clk(clk),
		.reset(reset),
		.rawIn(compareRaw),
		.enable(control_r[comparator_pkg::CTL_ON_BIT]),
		.invert(control_r[comparator_pkg::CTL_INV_BIT]),
		.result(result)
	);

	// Previous result for toggle detection; it runs regardless of sleep.
	always_ff @(posedge clk) begin
		if (reset) begin
			resultPrev_r <= 1'b0;
		end else begin
			resultPrev_r <= result;
		end
	end

	// Edges of the internal, polarity-adjusted bit, never of a pin.
	always_comb begin
		toggle = result ^ resultPrev_r;
		// A flag already set gives no new wake event, so pre-setting suppresses wake.
		wakeEvt = toggle && sleepMode && control_r[comparator_pkg::CTL_ON_BIT]
			&& !status_r[comparator_pkg::ST_TOGGLE_BIT];
	end

	// Sticky status: a read clears, but a same-cycle event wins over the clear.
	always_comb begin
		statusNxt = status_r;
		if (req.rd && req.addr == comparator_pkg::ADDR_STATUS) begin
			statusNxt = comparator_pkg::EVT_NONE;
		end
		if (req.wr && req.addr == comparator_pkg::ADDR_STATUS) begin
			statusNxt = statusNxt | req.wdata[1:0];
		end
		if (toggle) begin
			statusNxt[comparator_pkg::ST_TOGGLE_BIT] = 1'b1;
		end
		if (wakeEvt) begin
			statusNxt[comparator_pkg::ST_WAKE_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			status_r <= comparator_pkg::EVT_NONE;
		end else begin
			status_r <= statusNxt;
		end
	end

	// Interrupt enables share the status layout.
	always_ff @(posedge clk) begin
		if (reset) begin
			mask_r <= comparator_pkg::EVT_NONE;
		end else if (req.wr && req.addr == comparator_pkg::ADDR_MASK) begin
			mask_r <= req.wdata[1:0];
		end
	end

	// Read mux; unmapped offsets return zero.
	always_comb begin
		readNxt = 8'h00;
		unique case (req.addr)
			comparator_pkg::ADDR_CONTROL: begin
				readNxt = control_r;
				readNxt[comparator_pkg::CTL_RESULT_BIT] = result;
			end
			comparator_pkg::ADDR_TRIM: readNxt = trim_r;
			comparator_pkg::ADDR_STATUS: readNxt = {6'h00, status_r};
			comparator_pkg::ADDR_MASK: readNxt = {6'h00, mask_r};
			default: readNxt = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			regRdata <= 8'h00;
		end else begin
			regRdata <= req.rd ? readNxt : 8'h00;
		end
	end

	// Analog controls; hysteresis follows the mode automatically.
	always_comb begin
		ctl.powerOn = control_r[comparator_pkg::CTL_ON_BIT];
		ctl.hysteresisOn = !trim_r[comparator_pkg::TRIM_CAL_BIT];
		ctl.calibMode = trim_r[comparator_pkg::TRIM_CAL_BIT];
		ctl.calibRefPos = trim_r[comparator_pkg::TRIM_REF_BIT];
		ctl.trim = trim_r[comparator_pkg::TRIM_W-1:0];
	end

	// Registered outputs; they lag the controls by one cycle, harmless for analog.
	always_ff @(posedge clk) begin
		if (reset) begin
			comparatorOn <= 1'b0;
			hysteresisOn <= 1'b1;
			calibrationModeSel <= 1'b0;
			calibReferenceSel <= 1'b0;
			offsetTrimValue <= comparator_pkg::TRIM_RESET[comparator_pkg::TRIM_W-1:0];
		end else begin
			comparatorOn <= ctl.powerOn;
			hysteresisOn <= ctl.hysteresisOn;
			calibrationModeSel <= ctl.calibMode;
			calibReferenceSel <= ctl.calibRefPos;
			offsetTrimValue <= ctl.trim;
		end
	end

	// Interrupt and wake outputs are levels from the sticky bits.
	always_ff @(posedge clk) begin
		if (reset) begin
			irq <= 1'b0;
			wakeRequest <= 1'b0;
			compareResultBit <= 1'b0;
		end else begin
			irq <= |(statusNxt & mask_r);
			wakeRequest <= statusNxt[comparator_pkg::ST_WAKE_BIT];
			compareResultBit <= result;
		end
	end
endmodule : comparator_offset_trim_irq

// ===== design/comparator_pkg.sv
// What this block does
// - Trim register bit 6 selects calibration mode; zero is normal comparison.
// - Trim register bit 5 selects calibration reference; one is positive input.
// - Trim bits 4..0 hold a read/write offset correction that is retained.
// - Any change of the result bit sets the interrupt flag.
// - Flag set with its enable set raises the interrupt request.
// - Interrupt comes from the internal result bit after polarity, not a pin.
// - In sleep or idle with comparator on, a flag-setting toggle requests wake-up.
// - Comparator keeps running and updating its result during sleep or idle.
// - Hysteresis is on in normal mode and off in calibration mode.
// - With the comparator disabled the result is forced to zero and power is off.
// - The result bit is inverted when the polarity select bit is one.
package comparator_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int TRIM_W = 5;
	// Register offsets.
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_TRIM = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_MASK = 4'h3;
	// Control register fields.
	localparam int CTL_ON_BIT = 6;
	localparam int CTL_INV_BIT = 5;
	localparam int CTL_RESULT_BIT = 4;
	localparam int CTL_SLEEP_BIT = 0;
	// Trim register fields.
	localparam int TRIM_CAL_BIT = 6;
	localparam int TRIM_REF_BIT = 5;
	localparam logic [7:0] TRIM_RESET = 8'h10;
	localparam logic [7:0] TRIM_WMASK = 8'h7F;
	// Status and mask layout.
	localparam int ST_TOGGLE_BIT = 0;
	localparam int ST_WAKE_BIT = 1;
	localparam logic [1:0] EVT_NONE = 2'h0;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef struct packed {
		logic powerOn;
		logic hysteresisOn;
		logic calibMode;
		logic calibRefPos;
		logic [TRIM_W-1:0] trim;
	} analog_ctl_t;
endpackage : comparator_pkg

// ===== design/result_sync.sv
`timescale 1ns/1ns
// Two-stage synchronizer with polarity and enable gating on the stable stage.
module result_sync (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Raw analog output and controls.
	input wire logic rawIn,
	input wire logic enable,
	input wire logic invert,
	// Conditioned result.
	output logic result
);
	logic meta_r;
	logic stable_r;

	// The first stage feeds only the second stage, never the edge logic.
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_r <= 1'b0;
			stable_r <= 1'b0;
		end else begin
			meta_r <= rawIn;
			stable_r <= meta_r;
		end
	end

	// Disabled comparator reads zero whatever the polarity; polarity applies under the enable gate.
	always_comb begin
		result = enable & (stable_r ^ invert);
	end
endmodule : result_sync

// ===== tb/comparator_offset_trim_irq_checker.sv
`timescale 1ns/1ns
// Port checks; every property runs on clk and is held off while reset is high.
module comparator_offset_trim_irq_checker (
	// Watched ports.
	input wire logic clk,
	input wire logic reset,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdata,
	input wire logic compareRaw,
	input wire logic comparatorOn,
	input wire logic hysteresisOn,
	input wire logic calibrationModeSel,
	input wire logic calibReferenceSel,
	input wire logic [4:0] offsetTrimValue,
	input wire logic sleepMode,
	input wire logic irq,
	input wire logic wakeRequest,
	input wire logic compareResultBit
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Write strobe aimed at the trim register.
	wire logic trimWr = regWr && regAddr == comparator_pkg::ADDR_TRIM;
	// Trim fields, their read-back and hysteresis, which must follow the mode bit.
	// The trim register and the output stage behind it give two edges of delay.
	property p_trim; trimWr |-> ##2 {calibrationModeSel, calibReferenceSel, offsetTrimValue}
		== $past(regWdata[6:0], 2); endproperty
	a_trim: assert property (p_trim) else $error("trim write lost");
	property p_hold; !trimWr |-> ##2 $stable(offsetTrimValue); endproperty
	a_hold: assert property (p_hold) else $error("trim moved");
	property p_rd; regRd && regAddr == comparator_pkg::ADDR_TRIM |=> regRdata[7] == 1'b0
		&& regRdata[4:0] == offsetTrimValue; endproperty
	a_rd: assert property (p_rd) else $error("trim read wrong");
	property p_hyst; hysteresisOn != calibrationModeSel; endproperty
	a_hyst: assert property (p_hyst) else $error("hysteresis wrong");
	// A raw change needs three edges to reach the result, so two quiet edges come first.
	property p_sync; $changed(compareRaw) |=> $stable(compareResultBit) [*2]; endproperty
	a_sync: assert property (p_sync) else $error("result too early");
	property p_off; !comparatorOn [*4] |-> !compareResultBit; endproperty
	a_off: assert property (p_off) else $error("result set while off");
	// Interrupt rises only soon after a raw change or a register write; wake-up only soon after a register write or while in sleep.
	property p_irq; (!regWr && $stable(compareRaw)) [*6] |-> !$rose(irq); endproperty
	a_irq: assert property (p_irq) else $error("irq without cause");
	property p_wake; (!regWr && !sleepMode) [*6] |-> !$rose(wakeRequest); endproperty
	a_wake: assert property (p_wake) else $error("wake while awake");
endmodule : comparator_offset_trim_irq_checker
bind comparator_offset_trim_irq comparator_offset_trim_irq_checker chk (.*);

// ===== tb/comparator_offset_trim_irq_test.sv
`timescale 1ns/1ns
// Counts a comparison and reports a mismatch at once.
`define CHK(n, e, s) begin \
	cmp_count++; \
	if ((s) !== (e)) begin bad_count++; $display("mismatch %s expected %h seen %h", n, e, s); end \
end
// Trim table first, then interrupt, polarity, mask, wake-up and enable cases by hand.
module comparator_offset_trim_irq_test;
	logic clk, reset, regWr, regRd, compareRaw, sleepMode, irq, wakeRequest, comparatorOn;
	logic hysteresisOn, calibrationModeSel, calibReferenceSel, compareResultBit;
	logic [3:0] regAddr;
	logic [4:0] offsetTrimValue;
	logic [7:0] regWdata, regRdata, q;
	logic [4:0] lo, hi;
	logic first;
	int bad_count, cmp_count;
	// Trim rows: byte written above the byte that must read back.
	logic [15:0] rows [4] = '{16'hFF7F, 16'h6060, 16'h1F1F, 16'h8000};
	comparator_offset_trim_irq dut (.*);
	// Free-running 20 MHz clock.
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// One-cycle register write.
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr
	// One-cycle read; the data stand only in the following cycle, so take them there.
	task rd(input logic [3:0] a);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 q = regRdata;
	endtask : rd
	// Enough edges for the synchronizer and the flag to settle.
	task w5;
		repeat (5) @(posedge clk);
		#1;
	endtask : w5
	task tg;
		compareRaw <= ~compareRaw;
		w5;
	endtask : tg
	task give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict
	// Main sequence; every wait is a fixed count, so nothing can hang.
	initial begin
		{reset, regWr, regRd, compareRaw, sleepMode} = 5'h10;
		regAddr = 4'h0;
		regWdata = 8'h00;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rd(4'h1);
		`CHK("trim reset", 8'h10, q)
		`CHK("hysteresis reset", 1'b1, hysteresisOn)
		foreach (rows[i]) begin
			wr(4'h1, rows[i][15:8]);
			rd(4'h1);
			`CHK("trim read", rows[i][7:0], q)
			`CHK("trim out", rows[i][4:0], offsetTrimValue)
			`CHK("mode", rows[i][6], calibrationModeSel)
			`CHK("reference", rows[i][5], calibReferenceSel)
			`CHK("hysteresis", ~rows[i][6], hysteresisOn)
		end
		wr(4'h3, 8'h01);
		wr(4'h0, 8'h40);
		tg;
		`CHK("result", 1'b1, compareResultBit)
		`CHK("irq", 1'b1, irq)
		rd(4'h2);
		`CHK("status", 8'h01, q)
		w5;
		`CHK("irq cleared", 1'b0, irq)
		wr(4'h0, 8'h60);
		w5;
		tg;
		`CHK("inverted", 1'b1, compareResultBit)
		rd(4'h2);
		wr(4'h3, 8'h00);
		tg;
		`CHK("masked irq", 1'b0, irq)
		rd(4'h2);
		`CHK("masked flag", 8'h01, q)
		sleepMode <= 1'b1;
		tg;
		`CHK("wake", 1'b1, wakeRequest)
		`CHK("sleep result", 1'b1, compareResultBit)
		rd(4'h2);
		wr(4'h2, 8'h01);
		tg;
		`CHK("no wake", 1'b0, wakeRequest)
		sleepMode <= 1'b0;
		wr(4'h0, 8'h40);
		w5;
		`CHK("plain", 1'b1, compareResultBit)
		`CHK("power on", 1'b1, comparatorOn)
		wr(4'h0, 8'h00);
		w5;
		`CHK("off", 1'b0, compareResultBit)
		`CHK("power off", 1'b0, comparatorOn)
		rd(4'hF);
		`CHK("unmapped", 8'h00, q)
		// Calibration sweep; the bench plays the analog side with a switching point at 0B.
		wr(4'h0, 8'h40);
		lo = 5'h1F;
		hi = 5'h00;
		first = 1'b0;
		for (int t = 0; t < 32; t++) begin
			wr(4'h1, 8'h60 | 8'(t));
			w5;
			compareRaw <= offsetTrimValue >= 5'h0B;
			w5;
			rd(4'h0);
			if (t == 0) begin
				first = q[4];
			end else if (q[4] != first) begin
				lo = 5'(t);
				break;
			end
		end
		for (int t = 31; t >= 0; t--) begin
			wr(4'h1, 8'h60 | 8'(t));
			w5;
			compareRaw <= offsetTrimValue >= 5'h0B;
			w5;
			rd(4'h0);
			if (t == 31) begin
				first = q[4];
			end else if (q[4] != first) begin
				hi = 5'(t);
				break;
			end
		end
		`CHK("lower point", 5'h0B, lo)
		`CHK("upper point", 5'h0A, hi)
		wr(4'h1, {3'h0, 5'((6'(lo) + 6'(hi)) >> 1)});
		rd(4'h1);
		`CHK("final trim", 8'h0A, q)
		give_verdict;
	end
endmodule : comparator_offset_trim_irq_test
